// >>> bil_fifo.sv
// Parameterised staging FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module bil_fifo #(
	parameter int W = 24,
	parameter int D = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         inVld,
	output logic              inRdy,
	input  wire logic [W-1:0] inData,
	output logic              outVld,
	input  wire logic         outRdy,
	output logic [W-1:0]      outData
);
	localparam int PW = $clog2(D);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(D);

	logic [W-1:0]  mem_ff [D];
	logic [PW-1:0] wrPtr_ff;
	logic [PW-1:0] rdPtr_ff;
	logic [PW:0]   count_ff;
	logic          doPush;
	logic          doPop;

	// Full and empty come straight from the occupancy count.
	assign inRdy   = (count_ff != FULL_CNT);
	assign outVld  = (count_ff != '0);
	assign outData = mem_ff[rdPtr_ff];
	assign doPush  = inVld && inRdy;
	assign doPop   = outVld && outRdy;

	// Storage has no reset; only pointers and the count carry control state.
	always_ff @(posedge ref_clk) begin
		if (doPush) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	// Pointers wrap naturally because the depth is a power of two.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (doPush) wrPtr_ff <= wrPtr_ff + 1'b1;
			if (doPop) rdPtr_ff <= rdPtr_ff + 1'b1;
			if (doPush && !doPop) count_ff <= count_ff + 1'b1;
			else if (doPop && !doPush) count_ff <= count_ff - 1'b1;
		end
	end
endmodule // bil_fifo

// >>> bil_loader.sv
// Boot image loader with retest entry guard, top of the block.
// Functional notes
// - Each record's data goes to the destination address carried in that record.
// - Destinations 0x0000 to 0x11FF write the unified code/data RAM.
// - Destinations 0x7000 to 0x70FF map to internal RAM at offset minus base.
// - Only 0x7020 to 0x70EF of the internal window may be written by records.
// - Window is indirect only; no special function register is ever written.
// - All appended user blocks are processed until an end marker or NVM end.
// - A locked part keeps the debug port disabled on a normal boot.
// - Retest detected in the slot loads the factory region only, no user region.
// - Protection actions finish before the debug port opens for retest.
// - Protection flags are ignored unless the part is locked.
// - Locking sets the retest policy once, together with the locked state.
// - Debug kill keeps the port closed until reset and overrides all other flags.
// - RAM clear zeroes code/data RAM and internal RAM, keeping the factory region.
// - Internal RAM clearing spares register bank zero, the lowest 8 bytes.
// - RAM clear comes from the retest byte, debug kill from the lock byte.
// - RAM clear on retest is bit 5 of the retest protection byte.
// - Retest protection bits program once from zero to one, cleared only by reset.
// - Every boot ends with the boot finished flag set to one.
`timescale 1ns/1ps
module bil_loader
	import bil_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	input  wire logic               bootStart,
	input  wire logic               retestSeq,
	output logic [NVM_AW-1:0]       nvmAddr,
	output logic                    nvmRdReq,
	input  wire logic [7:0]         nvmRdData,
	input  wire logic               nvmRdValid,
	output logic                    xramWe,
	output logic [XRAM_AW-1:0]      xramAddr,
	output logic [7:0]              xramData,
	input  wire logic               xramReady,
	output logic                    iramWe,
	output logic [IRAM_AW-1:0]      iramAddr,
	output logic [7:0]              iramData,
	input  wire logic               iramReady,
	input  wire logic               progWe,
	input  wire logic [7:0]         progData,
	input  wire logic               lockReq,
	input  wire logic [7:0]         lockCtrlIn,
	input  wire logic [7:0]         retestProtIn,
	output logic                    partLocked,
	output logic                    debugPortEnable,
	output logic                    bootFinished,
	output logic                    bootBusy,
	output logic                    retestActive
);
	import bil_pkg::*;

	bil_state_t        state_ff;
	logic [7:0]        slotCnt_ff;
	logic [NVM_AW-1:0] nvmAddr_ff;
	logic              rdOn_ff;
	logic              rdWait_ff;
	logic [7:0]        recLen_ff;
	logic [15:0]       destAddr_ff;
	logic [15:0]       clrAddr_ff;
	logic              userPh_ff;
	logic              retest_ff;
	logic              clrDone_ff;
	logic              bootFinished_ff;
	logic              debugEn_ff;
	logic              wrVld_ff;
	logic              wrIram_ff;
	logic [15:0]       wrAddr_ff;
	logic [7:0]        wrData_ff;
	logic [7:0]        lockCtrl;
	logic [7:0]        retestProt;
	logic              locked;
	logic              killBit;
	logic              ramClearEff;
	logic              fifoInVld;
	logic              fifoInRdy;
	logic [FIFO_W-1:0] fifoInData;
	logic              fifoOutVld;
	logic              fifoOutRdy;
	logic [FIFO_W-1:0] fifoOutData;
	logic              wrAck;
	logic              recWritable;
	logic              pipeIdle;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// Protection bytes live in one-time cells next to the loader.
	bil_otp_bits u_otp (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.progWe       (progWe),
		.progData     (progData),
		.lockReq      (lockReq),
		.lockCtrlIn   (lockCtrlIn),
		.retestProtIn (retestProtIn),
		.lockCtrl     (lockCtrl),
		.retestProt   (retestProt),
		.locked       (locked)
	);

	// Flags count only on a locked part; kill sits in a different byte than RAM clear.
	assign killBit     = locked && lockCtrl[DEBUG_KILL_BIT];
	assign ramClearEff = locked && retestProt[RAM_CLEAR_BIT];

	// Records may target code/data RAM or the writable window slice, nothing else.
	assign recWritable = bil_is_xram(destAddr_ff) || bil_is_iwr(destAddr_ff);

	// One read outstanding at a time; data reads also wait for buffer room.
	assign nvmRdReq = rdOn_ff && !rdWait_ff && ((state_ff != S_DATA) || fifoInRdy);
	assign nvmAddr  = nvmAddr_ff;

	// Record bytes and clearing zeros share the staging buffer.
	always_comb begin
		fifoInVld  = 1'b0;
		fifoInData = {destAddr_ff, nvmRdData};
		if (state_ff == S_CLEAR) begin
			fifoInVld  = 1'b1;
			fifoInData = {clrAddr_ff, ZERO_BYTE};
		end else if (state_ff == S_DATA) begin
			fifoInVld = nvmRdValid && recWritable;
		end
	end

	bil_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.inVld   (fifoInVld),
		.inRdy   (fifoInRdy),
		.inData  (fifoInData),
		.outVld  (fifoOutVld),
		.outRdy  (fifoOutRdy),
		.outData (fifoOutData)
	);

	// Read handshake: the request pulse arms a wait that the returned byte ends.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdWait_ff <= 1'b0;
		end else if (nvmRdValid) begin
			rdWait_ff <= 1'b0;
		end else if (nvmRdReq) begin
			rdWait_ff <= 1'b1;
		end
	end

	// Main sequencer: slot, record parse, drain, optional clear, finish.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_ff    <= S_IDLE;
			slotCnt_ff  <= '0;
			nvmAddr_ff  <= NVM_FACT_BASE;
			rdOn_ff     <= 1'b0;
			recLen_ff   <= ZERO_BYTE;
			destAddr_ff <= XRAM_LO;
			clrAddr_ff  <= XRAM_LO;
			userPh_ff   <= 1'b0;
			retest_ff   <= 1'b0;
			clrDone_ff  <= 1'b0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (bootStart) begin
						state_ff   <= S_SLOT;
						slotCnt_ff <= '0;
						nvmAddr_ff <= NVM_FACT_BASE;
						userPh_ff  <= 1'b0;
						retest_ff  <= 1'b0;
						clrDone_ff <= 1'b0;
					end
				end
				S_SLOT: begin
					// A killed part never enters retest, so the sequence is ignored there.
					if (retestSeq && locked && !killBit) begin
						retest_ff <= 1'b1;
					end
					slotCnt_ff <= slotCnt_ff + 1'b1;
					if (slotCnt_ff == SLOT_LAST) begin
						state_ff <= S_LEN;
						rdOn_ff  <= 1'b1;
					end
				end
				S_LEN: begin
					if (nvmRdValid) begin
						nvmAddr_ff <= nvmAddr_ff + 1'b1;
						if ((nvmRdData == REC_END) || (nvmRdData == REC_ERASED)) begin
							// The factory end marker opens the user region unless in retest.
							if (!userPh_ff && !retest_ff && (nvmAddr_ff != NVM_LAST)) begin
								userPh_ff <= 1'b1;
							end else begin
								state_ff <= S_DRAIN;
								rdOn_ff  <= 1'b0;
							end
						end else begin
							recLen_ff <= nvmRdData;
							state_ff  <= S_AHI;
						end
					end
				end
				S_AHI: begin
					if (nvmRdValid) begin
						nvmAddr_ff        <= nvmAddr_ff + 1'b1;
						destAddr_ff[15:8] <= nvmRdData;
						state_ff          <= S_ALO;
					end
				end
				S_ALO: begin
					if (nvmRdValid) begin
						nvmAddr_ff       <= nvmAddr_ff + 1'b1;
						destAddr_ff[7:0] <= nvmRdData;
						state_ff         <= S_DATA;
					end
				end
				S_DATA: begin
					if (nvmRdValid) begin
						nvmAddr_ff  <= nvmAddr_ff + 1'b1;
						destAddr_ff <= destAddr_ff + 1'b1;
						recLen_ff   <= recLen_ff - 1'b1;
						// Appended blocks simply follow; parsing runs on to the next length byte.
						if (recLen_ff == 8'h01) begin
							state_ff <= S_LEN;
						end
						if (nvmAddr_ff == NVM_LAST) begin
							state_ff <= S_DRAIN;
							rdOn_ff  <= 1'b0;
						end
					end
				end
				S_DRAIN: begin
					// Waiting for an empty pipe keeps clearing and opening strictly ordered.
					if (pipeIdle) begin
						if (retest_ff && ramClearEff && !clrDone_ff) begin
							state_ff   <= S_CLEAR;
							clrAddr_ff <= XRAM_LO;
						end else begin
							state_ff <= S_FINISH;
						end
					end
				end
				S_CLEAR: begin
					if (fifoInRdy) begin
						if (clrAddr_ff == XRAM_CLR_HI) begin
							clrAddr_ff <= ICLR_LO;
						end else if (clrAddr_ff == IWIN_HI) begin
							clrDone_ff <= 1'b1;
							state_ff   <= S_DRAIN;
						end else begin
							clrAddr_ff <= clrAddr_ff + 1'b1;
						end
					end
				end
				S_FINISH: begin
					state_ff <= S_IDLE;
				end
				default: begin
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// Finish flag changes only at boot start and boot end; the debug port gate also closes on a lock request.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bootFinished_ff <= 1'b0;
			debugEn_ff      <= 1'b0;
		end else if ((state_ff == S_IDLE) && bootStart) begin
			bootFinished_ff <= 1'b0;
			debugEn_ff      <= 1'b0;
		end else if (state_ff == S_FINISH) begin
			bootFinished_ff <= 1'b1;
			debugEn_ff      <= (!locked && !lockReq) || (retest_ff && !killBit);
		end else if (lockReq && !locked) begin // Locking shuts a port left open earlier.
			debugEn_ff <= 1'b0;
		end
	end

	// Write stage: one registered beat toward whichever memory the address picks.
	assign wrAck      = wrVld_ff && (wrIram_ff ? iramReady : xramReady);
	assign fifoOutRdy = !wrVld_ff || wrAck;
	assign pipeIdle   = !fifoOutVld && !wrVld_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wrVld_ff  <= 1'b0;
			wrIram_ff <= 1'b0;
			wrAddr_ff <= XRAM_LO;
			wrData_ff <= ZERO_BYTE;
		end else if (fifoOutVld && fifoOutRdy) begin
			wrVld_ff  <= 1'b1;
			wrIram_ff <= bil_is_iwin(fifoOutData[23:8]);
			wrAddr_ff <= fifoOutData[23:8];
			wrData_ff <= fifoOutData[7:0];
		end else if (wrAck) begin
			wrVld_ff <= 1'b0;
		end
	end

	// The window reaches internal RAM by address only; there is no path to registers.
	assign xramWe   = wrVld_ff && !wrIram_ff;
	assign iramWe   = wrVld_ff && wrIram_ff;
	assign xramAddr = wrAddr_ff[XRAM_AW-1:0];
	assign iramAddr = IRAM_AW'(wrAddr_ff - IWIN_LO);
	assign xramData = wrData_ff;
	assign iramData = wrData_ff;

	assign partLocked      = locked;
	assign debugPortEnable = debugEn_ff;
	assign bootFinished    = bootFinished_ff;
	assign bootBusy        = (state_ff != S_IDLE);
	assign retestActive    = retest_ff;

	// Address header steps feeding the data phase.
	sequence sLowByte;
		(state_ff == S_ALO) && nvmRdValid;
	endsequence

	sequence sFirstData;
		(state_ff == S_DATA);
	endsequence

	a_dest_from_rec : assert property (sLowByte |=> destAddr_ff[7:0] == $past(nvmRdData))
		else $error("Destination low byte not taken from the record.");

	a_push_at_dest : assert property (sLowByte ##1 sFirstData |->
		fifoInData[15:8] == $past(nvmRdData))
		else $error("First data byte pushed to the wrong address.");

	a_xram_range : assert property (xramWe |-> wrAddr_ff <= XRAM_HI)
		else $error("Code/data RAM write outside its region.");

	a_iram_map : assert property (iramWe |-> bil_is_iwin(wrAddr_ff) &&
		(iramAddr == wrAddr_ff[7:0]))
		else $error("Internal RAM write not mapped from the window.");

	a_rec_window : assert property ((state_ff == S_DATA) && fifoInVld &&
		(fifoInData[23:8] >= IWIN_LO) |-> bil_is_iwr(fifoInData[23:8]))
		else $error("Record wrote a protected internal RAM byte.");

	a_bank_zero : assert property (iramWe |-> iramAddr >= ICLR_LO[7:0])
		else $error("Register bank zero was written.");

	a_locked_closed : assert property (locked && !retest_ff && bootFinished_ff
		|-> !debugEn_ff)
		else $error("Debug port open on a locked part.");

	a_kill_closed : assert property (killBit |-> !debugEn_ff && !retest_ff)
		else $error("Debug port open despite the kill flag.");

	a_retest_factory : assert property (retest_ff |-> !userPh_ff)
		else $error("User region read during retest.");

	a_open_after : assert property ($rose(debugEn_ff) |->
		$past(pipeIdle) && (clrDone_ff || !ramClearEff || !retest_ff))
		else $error("Debug port opened before protection actions ended.");

	a_flags_ignored : assert property (!locked |-> !ramClearEff && !killBit && !retest_ff &&
		(debugEn_ff || !bootFinished_ff))
		else $error("Protection flags acted on an unlocked part.");

	a_clear_zero : assert property ((state_ff == S_CLEAR) |->
		(fifoInData[7:0] == ZERO_BYTE) && (clrAddr_ff <= XRAM_CLR_HI || clrAddr_ff >= ICLR_LO))
		else $error("Clearing wrote nonzero data or a kept byte.");

	a_finish_flag : assert property ((state_ff == S_FINISH) |=>
		bootFinished_ff && (state_ff == S_IDLE))
		else $error("Boot ended without the finished flag.");
endmodule // bil_loader

// >>> bil_nvm_model.sv
// Partner model of the non-volatile image store that answers byte reads.
`timescale 1ns/1ps
module bil_nvm_model
	import bil_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic              slowMode,
	input  wire logic [NVM_AW-1:0] nvmAddr,
	input  wire logic              nvmRdReq,
	output logic [7:0]             nvmRdData,
	output logic                   nvmRdValid
);
	logic [7:0]        mem [0:8191];
	logic              busyFf;
	logic [1:0]        waitFf;
	logic [NVM_AW-1:0] addrFf;
	logic [7:0]        dataFf;
	logic              validFf;

	// One read in flight; the data lines toggle between answers so a stale byte never looks valid.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busyFf  <= 1'b0;
			waitFf  <= 2'h0;
			addrFf  <= '0;
			dataFf  <= 8'h00;
			validFf <= 1'b0;
		end else begin
			validFf <= 1'b0;
			dataFf  <= ~dataFf;
			if (nvmRdReq && !busyFf) begin
				busyFf <= 1'b1;
				addrFf <= nvmAddr;
				waitFf <= slowMode ? 2'h3 : 2'h0; // Slow mode stretches every answer.
			end else if (busyFf && waitFf == 2'h0) begin
				busyFf  <= 1'b0;
				validFf <= 1'b1;
				dataFf  <= mem[addrFf];
			end else if (busyFf) begin
				waitFf <= waitFf - 2'h1;
			end
		end
	end

	assign nvmRdData  = dataFf;
	assign nvmRdValid = validFf;
endmodule // bil_nvm_model

// >>> bil_otp_bits.sv
// One-time programmable protection bytes and the locked program state.
`timescale 1ns/1ps
module bil_otp_bits
	import bil_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       progWe,
	input  wire logic [7:0] progData,
	input  wire logic       lockReq,
	input  wire logic [7:0] lockCtrlIn,
	input  wire logic [7:0] retestProtIn,
	output logic [7:0]      lockCtrl,
	output logic [7:0]      retestProt,
	output logic            locked
);
	logic [7:0] lockCtrl_ff;
	logic [7:0] retestProt_ff;
	logic       locked_ff;

	// Bits only ever go from zero to one; only sys_rst can clear them.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lockCtrl_ff   <= ZERO_BYTE;
			retestProt_ff <= ZERO_BYTE;
			locked_ff     <= 1'b0;
		end else if (!locked_ff) begin
			if (lockReq) begin
				locked_ff     <= 1'b1;
				lockCtrl_ff   <= lockCtrl_ff | lockCtrlIn;
				retestProt_ff <= retestProt_ff | retestProtIn | progData & {8{progWe}};
			end else if (progWe) begin
				retestProt_ff <= retestProt_ff | progData;
			end
		end
	end

	assign lockCtrl   = lockCtrl_ff;
	assign retestProt = retestProt_ff;
	assign locked     = locked_ff;

	a_otp_sticky : assert property (@(posedge ref_clk) disable iff (sys_rst)
		($past(retestProt_ff) & ~retestProt_ff) == ZERO_BYTE)
		else $error("A protection bit was cleared.");

	a_lock_policy : assert property (@(posedge ref_clk) disable iff (sys_rst)
		$past(locked_ff) |-> $stable(retestProt_ff) && $stable(lockCtrl_ff) && locked_ff)
		else $error("Retest policy changed after locking.");
endmodule // bil_otp_bits

// >>> bil_pkg.sv
// Shared constants, types and address decoding for the boot image loader.
package bil_pkg;

	// Destination address windows seen by the loader.
	localparam logic [15:0] XRAM_LO      = 16'h0000;
	localparam logic [15:0] XRAM_HI      = 16'h11ff;
	localparam logic [15:0] XRAM_CLR_HI  = 16'h11bf; // Top bytes keep the factory region.
	localparam logic [15:0] IWIN_LO      = 16'h7000;
	localparam logic [15:0] IWIN_HI      = 16'h70ff;
	localparam logic [15:0] IWR_LO       = 16'h7020;
	localparam logic [15:0] IWR_HI       = 16'h70ef;
	localparam logic [15:0] ICLR_LO      = 16'h7008;

	// Port widths of the memories and the non-volatile store.
	localparam int XRAM_AW = 13;
	localparam int IRAM_AW = 8;
	localparam int NVM_AW  = 13;
	localparam logic [NVM_AW-1:0] NVM_FACT_BASE = 13'h0000;
	localparam logic [NVM_AW-1:0] NVM_LAST      = 13'h1fff;

	// Record markers: a length byte of these values ends a region.
	localparam logic [7:0] REC_END    = 8'h00;
	localparam logic [7:0] REC_ERASED = 8'hff;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;

	// Protection bit positions.
	localparam int RAM_CLEAR_BIT  = 5;
	localparam int DEBUG_KILL_BIT = 0;

	// Retest detection slot, a least time, so the count rounds up.
	localparam int CLK_NS    = 10;
	localparam int SLOT_NS   = 1000;
	localparam int SLOT_CYC  = (SLOT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] SLOT_LAST = 8'(SLOT_CYC - 1);

	// Staging buffer shape: destination address plus data byte.
	localparam int FIFO_W = 24;
	localparam int FIFO_D = 8;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_SLOT   = 4'h1,
		S_LEN    = 4'h2,
		S_AHI    = 4'h3,
		S_ALO    = 4'h4,
		S_DATA   = 4'h5,
		S_DRAIN  = 4'h6,
		S_CLEAR  = 4'h7,
		S_FINISH = 4'h8
	} bil_state_t;

	// True for destinations that land in the code/data RAM.
	function automatic logic bil_is_xram(input logic [15:0] a);
		return (a >= XRAM_LO) && (a <= XRAM_HI);
	endfunction

	// True for destinations inside the internal RAM window.
	function automatic logic bil_is_iwin(input logic [15:0] a);
		return (a >= IWIN_LO) && (a <= IWIN_HI);
	endfunction

	// True for the writable slice of the internal RAM window.
	function automatic logic bil_is_iwr(input logic [15:0] a);
		return (a >= IWR_LO) && (a <= IWR_HI);
	endfunction

endpackage

// >>> boot_image_loader_retest_guard_tb_top.sv
// Self-checking testbench for the boot image loader and its retest guard.
`timescale 1ns/1ps
module boot_image_loader_retest_guard_tb_top;
	import bil_pkg::*;
	logic              ref_clk, sys_rst, bootStart, retestSeq, slowMode;
	logic              xramReady, iramReady, progWe, lockReq, nvmRdValid, nvmRdReq;
	logic              xramWe, iramWe, partLocked, debugPortEnable, bootFinished;
	logic              bootBusy, retestActive;
	logic [7:0]        progData, lockCtrlIn, retestProtIn, nvmRdData;
	logic [7:0]        xramData, iramAddr, iramData;
	logic [NVM_AW-1:0] nvmAddr;
	logic [XRAM_AW-1:0] xramAddr;
	logic [7:0]        xmem [0:8191];
	logic [7:0]        imem [0:255];
	logic [7:0]        ex [0:8191];
	logic [7:0]        ei [0:255];
	logic [31:0]       seed;
	logic [15:0]       recDest [$];
	int                recLen [$];
	int                recOff [$];
	bit                recUser [$];
	int                error_cnt, cmp_count, pos;

	bil_loader i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bootStart(bootStart),
		.retestSeq(retestSeq), .nvmAddr(nvmAddr), .nvmRdReq(nvmRdReq), .nvmRdData(nvmRdData),
		.nvmRdValid(nvmRdValid), .xramWe(xramWe), .xramAddr(xramAddr), .xramData(xramData),
		.xramReady(xramReady), .iramWe(iramWe), .iramAddr(iramAddr), .iramData(iramData),
		.iramReady(iramReady), .progWe(progWe), .progData(progData), .lockReq(lockReq),
		.lockCtrlIn(lockCtrlIn), .retestProtIn(retestProtIn), .partLocked(partLocked),
		.debugPortEnable(debugPortEnable), .bootFinished(bootFinished), .bootBusy(bootBusy),
		.retestActive(retestActive));

	bil_nvm_model i_nvm (.ref_clk(ref_clk), .sys_rst(sys_rst), .slowMode(slowMode),
		.nvmAddr(nvmAddr), .nvmRdReq(nvmRdReq), .nvmRdData(nvmRdData), .nvmRdValid(nvmRdValid));

	// Xorshift source; the fixed start value keeps every run identical.
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// The clock toggles every half period of 10 ns.
	always #5 ref_clk = ~ref_clk;

	// Memory stand-ins stall at random and store each write they take.
	always @(posedge ref_clk) begin
		xramReady <= (rnd() & 32'h3) != 32'h0;
		iramReady <= (rnd() & 32'h3) != 32'h0;
		if (xramWe && xramReady)
			xmem[xramAddr] <= xramData;
		if (iramWe && iramReady)
			imem[iramAddr] <= iramData;
		if (((xramWe && xramReady) || (iramWe && iramReady)) && retestActive && debugPortEnable) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, debugPortEnable, 1'b0);
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wrap_up();
		$display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Appends one record to the image: length, destination high and low, then random data.
	task add_rec(input logic [15:0] d, input int n, input bit u);
		recDest.push_back(d);
		recLen.push_back(n);
		recOff.push_back(pos + 3);
		recUser.push_back(u);
		i_nvm.mem[pos] = 8'(n);
		i_nvm.mem[pos + 1] = d[15:8];
		i_nvm.mem[pos + 2] = d[7:0];
		for (int j = 0; j < n; j++)
			i_nvm.mem[pos + 3 + j] = 8'(rnd());
		pos += 3 + n;
	endtask

	task add_end(input logic [7:0] m);
		i_nvm.mem[pos] = m;
		pos++;
	endtask

	task fill();
		for (int i = 0; i < 8192; i++)
			xmem[i] = 8'(i) ^ 8'h5a;
		for (int i = 0; i < 256; i++)
			imem[i] = 8'(i) ^ 8'ha5;
	endtask

	task pulse(input logic lk, input logic [7:0] a, input logic [7:0] b);
		@(posedge ref_clk);
		lockReq <= lk;
		progWe <= !lk;
		progData <= b;
		lockCtrlIn <= a;
		retestProtIn <= b;
		@(posedge ref_clk);
		lockReq <= 1'b0;
		progWe <= 1'b0;
		slowMode <= lk;
	endtask

	task do_reset();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk({partLocked, debugPortEnable, bootFinished}, 16'h0);
	endtask

	// Starts a boot with the retest pins as given and waits for it to end.
	task boot(input logic rt);
		int k;
		fill();
		@(posedge ref_clk);
		bootStart <= 1'b1;
		retestSeq <= rt;
		@(posedge ref_clk);
		bootStart <= 1'b0;
		@(negedge ref_clk);
		chk({15'h0, bootBusy}, 16'h1);
		k = 0;
		while (!(bootFinished === 1'b1 && bootBusy === 1'b0) && k < 40000) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 40000) begin
			error_cnt++;
			wrap_up();
		end
		@(posedge ref_clk);
		retestSeq <= 1'b0;
	endtask

	// Works out both memories from the image, then compares every byte.
	task check_mem(input bit rt, input bit clr, input logic [2:0] st);
		logic [15:0] d;
		for (int i = 0; i < 8192; i++)
			ex[i] = 8'(i) ^ 8'h5a;
		for (int i = 0; i < 256; i++)
			ei[i] = 8'(i) ^ 8'ha5;
		foreach (recDest[r])
			if (!(rt && recUser[r]))
				for (int j = 0; j < recLen[r]; j++) begin
					d = recDest[r] + 16'(j);
					if (d <= XRAM_HI)
						ex[d[12:0]] = i_nvm.mem[recOff[r] + j];
					else if (d >= IWR_LO && d <= IWR_HI)
						ei[d[7:0]] = i_nvm.mem[recOff[r] + j];
				end
		if (clr) begin
			for (int i = 0; i <= int'(XRAM_CLR_HI); i++)
				ex[i] = 8'h00;
			for (int i = int'(ICLR_LO[7:0]); i < 256; i++)
				ei[i] = 8'h00;
		end
		for (int i = 0; i < 8192; i++)
			chk({8'h00, xmem[i]}, {8'h00, ex[i]});
		for (int i = 0; i < 256; i++)
			chk({8'h00, imem[i]}, {8'h00, ei[i]});
		@(negedge ref_clk);
		chk({debugPortEnable, retestActive, partLocked, bootFinished}, {st, 1'b1});
	endtask

	// Main sequence: image build, reset, then five boots over four protection settings.
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{bootStart, retestSeq, progWe, lockReq} = 4'h0;
		{progData, lockCtrlIn, retestProtIn} = 24'h0;
		slowMode = 1'b1;
		seed = 32'h9e5a;
		error_cnt = 0;
		cmp_count = 0;
		pos = 0;
		add_rec(16'h0010, 3, 0);
		add_rec(16'h11fe, 2, 0);
		add_rec(16'h701c, 8, 0);
		add_rec(16'h70ec, 6, 0);
		add_rec(16'h11fc, 6, 0);
		add_rec(16'h3000, 2, 0);
		add_end(REC_ERASED);
		add_rec(16'h11f0, 4, 1);
		add_rec(16'h0200, 5, 1);
		add_rec(16'h70a0, 3, 1);
		add_rec(16'h0200, 2, 1);
		add_end(REC_END);
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		pulse(1'b0, 8'h00, 8'h20);
		boot(1'b1);
		check_mem(0, 0, 3'b100);
		pulse(1'b1, 8'h00, 8'h00);
		boot(1'b0);
		check_mem(0, 0, 3'b001);
		pulse(1'b1, 8'h01, 8'h00);
		boot(1'b1);
		check_mem(1, 1, 3'b111);
		do_reset();
		pulse(1'b1, 8'h01, 8'h20);
		boot(1'b1);
		check_mem(0, 0, 3'b001);
		do_reset();
		pulse(1'b1, 8'h00, 8'hdf);
		boot(1'b1);
		check_mem(1, 0, 3'b111);
		wrap_up();
	end
endmodule // boot_image_loader_retest_guard_tb_top
